// ==== shared/boot_seq_pkg.sv ====
// package: option register layout, apb offsets, sequencer states and timing constants
package boot_seq_pkg;
  // apb byte offsets
  localparam logic [11:0] OFS_OPTION = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_CONTROL = 12'h008;
  // option byte field positions
  localparam int BIT_BOOT_LO = 0;
  localparam int BIT_NMI_EN = 2;
  localparam int BIT_PIN_EN = 3;
  localparam int BIT_BOOT_HI = 4;
  localparam int BIT_FAST_INIT = 5;
  localparam logic [7:0] OPTION_ERASED = 8'hff;
  localparam logic [7:0] OPTION_LIVE_MASK = 8'h3d;
  // divider reset values chosen by the boot field
  localparam logic [3:0] DIV_BY8 = 4'h7;
  localparam logic [3:0] DIV_BY4 = 4'h3;
  localparam logic [3:0] DIV_BY2 = 4'h1;
  localparam logic [3:0] DIV_BY1 = 4'h0;
  // processor start values
  localparam logic [31:0] VEC_SP_OFS = 32'h0000_0000;
  localparam logic [31:0] VEC_PC_OFS = 32'h0000_0004;
  localparam logic [31:0] LINK_START = 32'hffff_ffff;
  // least pin drive, in bus clock cycles
  localparam int PIN_LOW_BUS_CYCLES = 128;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  // sequencer states
  typedef enum logic [2:0] {
    ST_STATIC, ST_CLKGEN, ST_CLOCKS, ST_FLASH, ST_PIN, ST_RUN
  } seq_state_e;
  // clock and reset controls towards the system
  typedef struct packed {
    logic clkGenEn;
    logic sysClkEn;
    logic flashClkEn;
    logic busClkEn;
    logic coreClkEn;
    logic flashRstN;
    logic sysRstN;
  } clk_rst_s;
endpackage

// ==== core/boot_option_reset_sequencer.sv ====
// boot option register capture and reset exit sequencer with apb access
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/100ps

module boot_option_reset_sequencer #(
  parameter int BUS_DIV = 2
) (
  input  wire logic                         clock,
  input  wire logic                         rst_n,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [11:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         supplySafe,
  input  wire logic                         sysResetReq,
  input  wire logic                         vllsWake,
  input  wire logic                         vllsWakeViaPin,
  input  wire logic [7:0]                   optionByte,
  input  wire logic                         flashInitDone,
  input  wire logic                         resetPinIn,
  output logic                              resetPinOut,
  output logic                              resetPinOe,
  output logic                              resetPinPullup,
  output logic                              resetPinFilter,
  output logic                              resetPinWakeEn,
  output logic                              nmiEnable,
  output logic                              nmiWakeEn,
  output logic                              flashFastInit,
  output logic      [3:0]                   coreSysDiv,
  output logic                              recoveryExtend,
  output boot_seq_pkg::clk_rst_s            clkRst,
  output logic      [31:0]                  coreSpAddr,
  output logic      [31:0]                  corePcAddr,
  output logic      [31:0]                  coreLinkValue,
  output logic                              coreStart
);

  // boot divider decode, also used for the status readback
  function automatic logic [3:0] boot_div(input logic [1:0] field);
    logic [3:0] d;
    d = boot_seq_pkg::DIV_BY1;
    case (field)
      2'b00: d = boot_seq_pkg::DIV_BY8;
      2'b01: d = boot_seq_pkg::DIV_BY4;
      2'b10: d = boot_seq_pkg::DIV_BY2;
      default: d = boot_seq_pkg::DIV_BY1;
    endcase
    return d;
  endfunction

  boot_seq_pkg::seq_state_e stateFf;
  boot_seq_pkg::seq_state_e nxt_state;
  logic [7:0] optionFf;
  logic [7:0] busCntFf;
  logic [7:0] nxt_busCnt;
  logic [7:0] busDivFf;
  logic       pinEnFf;
  logic       pinCaughtFf;
  logic       holdCoreFf;
  logic       coreStartFf;

  // bus clock enable from divider; pin low time counts these pulses
  wire busTick = (busDivFf == 8'(BUS_DIV - 1));
  wire inReset = (stateFf != boot_seq_pkg::ST_RUN);
  wire pinMinMet = (busCntFf >= 8'(boot_seq_pkg::PIN_LOW_BUS_CYCLES - 1)) && busTick;
  // a disabled pin is never seen as a reset source
  wire pinReset = pinEnFf && pinCaughtFf && !resetPinIn;
  wire restart = sysResetReq || pinReset || (vllsWake && !inReset);
  wire [1:0] bootField = {optionFf[boot_seq_pkg::BIT_BOOT_HI],
                          optionFf[boot_seq_pkg::BIT_BOOT_LO]};

  // sequencer next state
  always_comb begin
    nxt_state = stateFf;
    case (stateFf)
      boot_seq_pkg::ST_STATIC: if (supplySafe) nxt_state = boot_seq_pkg::ST_CLKGEN;
      boot_seq_pkg::ST_CLKGEN: nxt_state = boot_seq_pkg::ST_CLOCKS;
      boot_seq_pkg::ST_CLOCKS: nxt_state = boot_seq_pkg::ST_FLASH;
      boot_seq_pkg::ST_FLASH: begin
        if (flashInitDone && (pinMinMet || busCntFf == 8'hff || vllsWake))
          nxt_state = boot_seq_pkg::ST_PIN;
      end
      boot_seq_pkg::ST_PIN: if (resetPinIn || !pinEnFf) nxt_state = boot_seq_pkg::ST_RUN;
      default: nxt_state = boot_seq_pkg::ST_RUN;
    endcase
    if (!supplySafe)
      nxt_state = boot_seq_pkg::ST_STATIC;
    else if (restart && stateFf == boot_seq_pkg::ST_RUN)
      nxt_state = boot_seq_pkg::ST_CLKGEN;
  end

  // bus cycle count, cleared in ST_CLKGEN and counting in every other state, saturates at 8'hff
  assign nxt_busCnt = (stateFf == boot_seq_pkg::ST_CLKGEN) ? 8'h00 :
                      (busTick && busCntFf != 8'hff) ? busCntFf + 8'h01 : busCntFf;

  // state and counters
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stateFf  <= boot_seq_pkg::ST_STATIC;
      busCntFf <= 8'h00;
      busDivFf <= 8'h00;
    end else begin
      stateFf  <= nxt_state;
      busCntFf <= nxt_busCnt;
      busDivFf <= busTick ? 8'h00 : busDivFf + 8'h01;
    end
  end

  // option capture: only in sequencing, never from the bus
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      optionFf <= boot_seq_pkg::OPTION_ERASED;
    end else if (stateFf == boot_seq_pkg::ST_CLKGEN) begin
      optionFf <= optionByte;
    end
  end

  // pin mode latched at power-on only; system resets keep it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pinEnFf     <= 1'b1;
      pinCaughtFf <= 1'b0;
    end else if (stateFf == boot_seq_pkg::ST_CLOCKS && !pinCaughtFf) begin
      pinEnFf     <= optionFf[boot_seq_pkg::BIT_PIN_EN];
      pinCaughtFf <= 1'b1;
    end
  end

  // core hold through a whole exit; start pulse at release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      holdCoreFf  <= 1'b1;
      coreStartFf <= 1'b0;
    end else begin
      holdCoreFf  <= (nxt_state != boot_seq_pkg::ST_RUN);
      coreStartFf <= holdCoreFf && (nxt_state == boot_seq_pkg::ST_RUN);
    end
  end

  // apb decode; the slave answers in the access cycle, no wait
  wire apbAccess = psel && penable;
  wire hitOption = (paddr == boot_seq_pkg::OFS_OPTION);
  wire hitStatus = (paddr == boot_seq_pkg::OFS_STATUS);
  wire hitControl = (paddr == boot_seq_pkg::OFS_CONTROL);
  wire mapped = hitOption || hitStatus || hitControl;
  wire [31:0] optionRead = {24'h0000_00, optionFf & boot_seq_pkg::OPTION_LIVE_MASK};
  // 23 pad + running + pin + divider + state fills the 32-bit word
  wire [31:0] statusRead = {23'h00_0000, !inReset, pinEnFf, boot_div(bootField),
                            stateFf};
  wire [31:0] readMux = hitOption ? optionRead :
                        hitStatus ? statusRead :
                        hitControl ? {31'h0000_0000, holdCoreFf} :
                        boot_seq_pkg::UNMAPPED_READ;

  // writes ignored everywhere; error on unmapped, option or status write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= readMux;
      pslverr <= psel && !penable && (!mapped || (pwrite && !hitControl));
    end
  end

  // pin, option and clock outputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      resetPinOut    <= 1'b0;
      resetPinOe     <= 1'b1;
      resetPinPullup <= 1'b0;
      resetPinFilter <= 1'b0;
      resetPinWakeEn <= 1'b0;
      nmiEnable      <= 1'b0;
      nmiWakeEn      <= 1'b0;
      flashFastInit  <= 1'b1;
      coreSysDiv     <= boot_seq_pkg::DIV_BY1;
      recoveryExtend <= 1'b0;
      clkRst         <= '0;
      coreSpAddr     <= boot_seq_pkg::VEC_SP_OFS;
      corePcAddr     <= boot_seq_pkg::VEC_PC_OFS;
      coreLinkValue  <= boot_seq_pkg::LINK_START;
      coreStart      <= 1'b0;
    end else begin
      resetPinOut <= 1'b0;
      // pin driven low until init done and least drive time met
      resetPinOe <= !(pinEnFf && stateFf inside {boot_seq_pkg::ST_CLKGEN,
                       boot_seq_pkg::ST_CLOCKS, boot_seq_pkg::ST_FLASH} && !vllsWake);
      resetPinPullup <= pinEnFf;
      resetPinFilter <= pinEnFf;
      resetPinWakeEn <= pinEnFf;
      nmiEnable <= optionFf[boot_seq_pkg::BIT_NMI_EN];
      nmiWakeEn <= optionFf[boot_seq_pkg::BIT_NMI_EN];
      flashFastInit <= optionFf[boot_seq_pkg::BIT_FAST_INIT];
      coreSysDiv <= boot_div(bootField);
      // slow init with divide extends recovery
      recoveryExtend <= !optionFf[boot_seq_pkg::BIT_FAST_INIT] && (bootField != 2'b11);
      clkRst.clkGenEn   <= (stateFf != boot_seq_pkg::ST_STATIC);
      clkRst.sysClkEn   <= !(stateFf inside {boot_seq_pkg::ST_STATIC, boot_seq_pkg::ST_CLKGEN});
      clkRst.flashClkEn <= !(stateFf inside {boot_seq_pkg::ST_STATIC, boot_seq_pkg::ST_CLKGEN});
      clkRst.busClkEn   <= !(stateFf inside {boot_seq_pkg::ST_STATIC, boot_seq_pkg::ST_CLKGEN});
      clkRst.flashRstN  <= (stateFf inside {boot_seq_pkg::ST_FLASH, boot_seq_pkg::ST_PIN,
                            boot_seq_pkg::ST_RUN});
      clkRst.coreClkEn  <= !inReset;
      clkRst.sysRstN    <= !inReset;
      coreSpAddr    <= boot_seq_pkg::VEC_SP_OFS;
      corePcAddr    <= boot_seq_pkg::VEC_PC_OFS;
      coreLinkValue <= boot_seq_pkg::LINK_START;
      coreStart     <= coreStartFf;
    end
  end

endmodule

// ==== tb/boot_seq_monitor.sv ====
// checker: reset exit order, pin timing and option register protection
`timescale 1ns/100ps
module boot_seq_monitor #(
  parameter int BUS_DIV = 2
) (
  input wire logic                   clock,
  input wire logic                   rst_n,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [11:0]            paddr,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   supplySafe,
  input wire logic                   flashInitDone,
  input wire logic                   resetPinIn,
  input wire logic                   resetPinOe,
  input wire logic                   resetPinPullup,
  input wire logic                   resetPinWakeEn,
  input wire logic [3:0]             coreSysDiv,
  input wire boot_seq_pkg::clk_rst_s clkRst,
  input wire logic [31:0]            coreSpAddr,
  input wire logic [31:0]            corePcAddr,
  input wire logic [31:0]            coreLinkValue,
  input wire logic                   coreStart
);
  // bus tick phase is unknown, so one tick of slack
  localparam int LOW_MIN = (boot_seq_pkg::PIN_LOW_BUS_CYCLES - 1) * BUS_DIV;
  logic [9:0] lowCnt_ff;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // cycles the pin has been driven low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) lowCnt_ff <= 10'h000;
    else lowCnt_ff <= resetPinOe ? 10'h000 : lowCnt_ff + 10'h001;
  end
  property p_static; !supplySafe [*3] |=> !clkRst.clkGenEn && !clkRst.sysRstN; endproperty
  a_static: assert property (p_static) else $error("clocks on before supply safe");
  property p_flash; $rose(clkRst.flashRstN) |-> !clkRst.sysRstN && clkRst.flashClkEn; endproperty
  a_flash: assert property (p_flash) else $error("flash released out of order");
  // a disabled pin is briefly driven before the option is known; only enabled pins count
  property p_pin_min; $rose(resetPinOe) && resetPinPullup |-> lowCnt_ff >= LOW_MIN; endproperty
  a_pin_min: assert property (p_pin_min) else $error("pin low too short");
  property p_release; $rose(resetPinOe) && resetPinPullup |-> $past(flashInitDone); endproperty
  a_release: assert property (p_release) else $error("pin released before flash init");
  property p_exit; $rose(clkRst.sysRstN) |-> (resetPinIn || !resetPinPullup) && resetPinOe; endproperty
  a_exit: assert property (p_exit) else $error("system left reset with pin low");
  property p_clocks;
    $rose(clkRst.sysRstN) |-> ##[0:2] clkRst.coreClkEn && clkRst.sysClkEn && clkRst.busClkEn;
  endproperty
  a_clocks: assert property (p_clocks) else $error("clocks missing at exit");
  property p_hold; clkRst.sysRstN && $past(clkRst.sysRstN) |-> $stable(coreSysDiv); endproperty
  a_hold: assert property (p_hold) else $error("divider moved while running");
  property p_ro;
    psel && penable && pready && pwrite && paddr == boot_seq_pkg::OFS_OPTION |-> pslverr;
  endproperty
  a_ro: assert property (p_ro) else $error("option write not refused");
  property p_wake; resetPinWakeEn == resetPinPullup; endproperty
  a_wake: assert property (p_wake) else $error("disabled pin can wake");
  property p_vec;
    coreStart |-> coreSpAddr == 32'h0000_0000 && corePcAddr == 32'h0000_0004
      && coreLinkValue == 32'hffff_ffff;
  endproperty
  a_vec: assert property (p_vec) else $error("core start values wrong");
  c_exit: cover property ($rose(clkRst.sysRstN));
  c_rel: cover property ($rose(resetPinOe));
  c_ro: cover property (psel && penable && pready && pwrite);
endmodule
bind boot_option_reset_sequencer boot_seq_monitor #(.BUS_DIV(BUS_DIV)) mon (.clock(clock),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .supplySafe(supplySafe), .flashInitDone(flashInitDone),
  .resetPinIn(resetPinIn), .resetPinOe(resetPinOe), .resetPinPullup(resetPinPullup),
  .resetPinWakeEn(resetPinWakeEn), .coreSysDiv(coreSysDiv), .clkRst(clkRst),
  .coreSpAddr(coreSpAddr), .corePcAddr(corePcAddr), .coreLinkValue(coreLinkValue),
  .coreStart(coreStart));

// ==== tb/flash_pin_model.sv ====
// far side: flash init timer and open-drain reset pin with pull-up
`timescale 1ns/100ps
module flash_pin_model (
  input  wire logic clock,
  input  wire logic flashRstN,
  input  wire logic resetPinOut,
  input  wire logic resetPinOe,
  input  wire logic holdLow,
  output logic      flashInitDone,
  output logic      resetPinIn
);
  logic [5:0] initCnt_ff;
  // init runs only while the controller is out of reset
  always_ff @(posedge clock) begin
    if (!flashRstN) initCnt_ff <= 6'h00;
    else if (initCnt_ff != 6'h3f) initCnt_ff <= initCnt_ff + 6'h01;
  end
  assign flashInitDone = (initCnt_ff == 6'h3f);
  // external driver may hold the pin
  assign resetPinIn = !(holdLow || (!resetPinOe && !resetPinOut));
endmodule

// ==== tb/tb_boot_option_reset_sequencer.sv ====
// testbench: boot option capture and reset exit through apb and pins
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_boot_option_reset_sequencer;
  logic                   clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic                   supplySafe = 0, sysResetReq = 0, holdLow = 0, pinEn, rerr;
  logic                   pready, pslverr, flashInitDone, resetPinIn, resetPinOut, resetPinOe;
  logic                   resetPinPullup, resetPinFilter, resetPinWakeEn, nmiEnable, nmiWakeEn;
  logic                   flashFastInit, recoveryExtend, coreStart;
  logic [11:0]            paddr = 12'h000;
  logic [31:0]            pwdata = 32'h0000_0000, prdata, rdat, coreSpAddr, corePcAddr, coreLinkValue;
  logic [7:0]             optionByte = 8'hff;
  logic [3:0]             coreSysDiv;
  boot_seq_pkg::clk_rst_s clkRst;
  logic [3:0]             expDiv [4] = '{4'h7, 4'h3, 4'h1, 4'h0};
  logic [7:0]             opts [4] = '{8'hc2, 8'h2d, 8'h14, 8'h11};
  int                     num_errors = 0, total_checks = 0, cycles = 0;
  boot_option_reset_sequencer #(.BUS_DIV(2)) dut (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supplySafe(supplySafe), .sysResetReq(sysResetReq),
    .vllsWake(1'b0), .vllsWakeViaPin(1'b0), .optionByte(optionByte),
    .flashInitDone(flashInitDone), .resetPinIn(resetPinIn), .resetPinOut(resetPinOut),
    .resetPinOe(resetPinOe), .resetPinPullup(resetPinPullup), .resetPinFilter(resetPinFilter),
    .resetPinWakeEn(resetPinWakeEn), .nmiEnable(nmiEnable), .nmiWakeEn(nmiWakeEn),
    .flashFastInit(flashFastInit), .coreSysDiv(coreSysDiv), .recoveryExtend(recoveryExtend),
    .clkRst(clkRst), .coreSpAddr(coreSpAddr), .corePcAddr(corePcAddr),
    .coreLinkValue(coreLinkValue), .coreStart(coreStart));
  flash_pin_model part (.clock(clock), .flashRstN(clkRst.flashRstN), .resetPinOut(resetPinOut),
    .resetPinOe(resetPinOe), .holdLow(holdLow), .flashInitDone(flashInitDone),
    .resetPinIn(resetPinIn));
  always #50 clock = ~clock;
  // hang guard, well above seven boots
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  task complete_run();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one apb transfer, held until pready is seen
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // mode 0 first power-on, 1 system reset, 2 new power-on; pin held low for hold cycles
  task boot(input logic [7:0] opt, input int mode, input int hold);
    int n;
    optionByte <= opt;
    holdLow <= (hold > 0);
    if (mode != 1) pinEn = opt[3];
    if (mode == 2) begin
      rst_n <= 0;
      repeat (3) @(posedge clock);
      rst_n <= 1;
    end
    if (mode == 1) begin
      @(posedge clock) sysResetReq <= 1;
      @(posedge clock) sysResetReq <= 0;
    end
    n = 0;
    while (coreStart !== 1'b1) begin
      @(posedge clock);
      n++;
      holdLow <= (n < hold);
    end
    holdLow <= 0;
    @(posedge clock);
    `CHK("held", pinEn, n > hold)
    `CHK("div", expDiv[{opt[4], opt[0]}], coreSysDiv)
    `CHK("fast", opt[5], flashFastInit)
    `CHK("ext", !opt[5] && !(opt[4] && opt[0]), recoveryExtend)
    `CHK("nmi", opt[2], nmiEnable)
    `CHK("nmiwake", opt[2], nmiWakeEn)
    `CHK("pin", pinEn, resetPinPullup)
    `CHK("filter", pinEn, resetPinFilter)
    apb(0, boot_seq_pkg::OFS_OPTION, 32'h0000_0000);
    `CHK("option", {24'h00_0000, opt & 8'h3d}, rdat)
    apb(0, boot_seq_pkg::OFS_STATUS, 32'h0000_0000);
    `CHK("status", {23'h00_0000, 1'b1, pinEn, expDiv[{opt[4], opt[0]}], 3'(boot_seq_pkg::ST_RUN)}, rdat)
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1;
    repeat (5) @(posedge clock);
    `CHK("static", 1'b0, clkRst.sysRstN)
    apb(0, boot_seq_pkg::OFS_OPTION, 32'h0000_0000);
    `CHK("erased", 32'h0000_003d, rdat)
    supplySafe <= 1;
    boot(8'hff, 0, 400);
    apb(1, boot_seq_pkg::OFS_OPTION, 32'h0000_0000);
    `CHK("werr", 1'b1, rerr)
    apb(0, boot_seq_pkg::OFS_OPTION, 32'h0000_0000);
    `CHK("kept", 32'h0000_003d, rdat)
    apb(0, 12'h0ff, 32'h0000_0000);
    `CHK("unmapped", 1'b1, rerr)
    `CHK("unmapdat", 32'h0000_0000, rdat)
    apb(0, boot_seq_pkg::OFS_CONTROL, 32'h0000_0000);
    `CHK("corehold", 32'h0000_0000, rdat)
    `CHK("cerr", 1'b0, rerr)
    optionByte <= 8'hc2;
    repeat (20) @(posedge clock);
    `CHK("late", 4'h0, coreSysDiv)
    // each boot field value through a system reset; pin setting must persist
    for (int i = 0; i < 4; i++) boot(opts[i], 1, 0);
    boot(8'hf7, 2, 5000);
    boot(8'hff, 1, 5000);
    complete_run();
  end
endmodule
